// ### zone_set_selector_regs.svh
// Purpose: constants for the zone set selector
// Assumes: 100 MHz ref_clk
// Notes:   timing counts derive from the printed figures
`ifndef ZONE_SET_SELECTOR_REGS_SVH
`define ZONE_SET_SELECTOR_REGS_SVH

`define ZSS_MAX_SETS      7'd70
`define ZSS_MAX_LINES     4'd8
`define ZSS_TWO_LINES     4'd2
`define ZSS_REDUCED_LINES 4'd3
`define ZSS_REDUCED_MAX   7'd6
`define ZSS_STEP_MS       30
`define ZSS_CLK_MHZ       100
`define ZSS_STEP_CYCLES   (`ZSS_STEP_MS * 1000 * `ZSS_CLK_MHZ)
`define ZSS_MIN_HAMMING   4'd2

`endif

// ### zone_set_selector_pkg.sv
// Purpose: types for the zone set selector
// Assumes: nothing
// Notes:   constants live in zone_set_selector_regs.svh
package zone_set_selector_pkg;
  typedef logic [6:0] set_idx_t;
  typedef logic [7:0] code_t;
  typedef logic [3:0] speed_t;
  typedef enum logic [4:0] {
    S_CHECK  = 5'b00001,
    S_LOOKUP = 5'b00010,
    S_IDLE   = 5'b00100,
    S_SETTLE = 5'b01000,
    S_FAULT  = 5'b10000
  } sel_state_e;
endpackage

// ### zone_set_selector.sv
// Purpose: picks the one active zone set from area switch lines
// Assumes: area_sw_pin is asynchronous, all else on ref_clk
// Notes:   configuration table is written through cfg_wr
`timescale 1ns/1ps
`include "zone_set_selector_regs.svh"
`default_nettype none

module zone_set_selector
  import zone_set_selector_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = `ZSS_STEP_CYCLES
)(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] area_sw_pin,
  input  wire speed_t     speed_range,
  input  wire logic       encoder_enable,
  input  wire logic       reduced_model,
  input  wire set_idx_t   zone_set_count,
  input  wire logic [3:0] area_switch_input_count,
  input  wire logic [5:0] delay_steps,
  input  wire logic       cfg_wr,
  input  wire set_idx_t   cfg_index,
  input  wire code_t      cfg_code,
  input  wire speed_t     cfg_speed,
  input  wire logic [1:0] zone_clear,
  input  wire logic       fault_clear,
  output var  set_idx_t   active_set,
  output var  logic       active_valid,
  output var  logic       monitor_enable,
  output var  logic       config_valid,
  output var  logic       fault,
  output var  logic [1:0] safety_output_pair
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [3:0] ones8(input code_t v);
    logic [3:0] n;
    n = 4'd0;
    for (int k = 0; k < 8; k++)
      n = n + {3'd0, v[k]};
    return n;
  endfunction

  function automatic code_t line_mask(input logic [3:0] n);
    code_t m;
    m = 8'h00;
    for (int k = 0; k < 8; k++)
      m[k] = (4'(k) < n);
    return m;
  endfunction

  // ------------------------------------------------------------
  // configuration table
  // ------------------------------------------------------------
  code_t  cfg_codes  [0:69];
  speed_t cfg_speeds [0:69];

  always_ff @(posedge ref_clk)
  begin
    if (cfg_wr && cfg_index < `ZSS_MAX_SETS)
    begin
      cfg_codes[cfg_index]  <= cfg_code;
      cfg_speeds[cfg_index] <= cfg_speed;
    end
  end

  // ------------------------------------------------------------
  // input synchroniser, three stages, accept on stage 2/3 agree
  // ------------------------------------------------------------
  code_t sync1;
  code_t sync2;
  code_t sync3;
  code_t in_code;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1   <= 8'h00;
      sync2   <= 8'h00;
      sync3   <= 8'h00;
      in_code <= 8'h00;
    end
    else
    begin
      sync1 <= area_sw_pin;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3)
        in_code <= sync3;
    end
  end

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  sel_state_e state;
  sel_state_e next_state;
  set_idx_t   chk_i;
  set_idx_t   chk_j;
  set_idx_t   scan;
  logic       chk_bad;
  logic [21:0] cyc_cnt;
  logic [5:0]  step_cnt;
  code_t      acc_code;
  speed_t     acc_speed;

  wire logic [3:0] eff_lines = reduced_model ? `ZSS_REDUCED_LINES
                                             : area_switch_input_count;
  wire code_t  mask     = line_mask(eff_lines);
  wire code_t  cur_code = in_code & mask;
  wire logic   multi    = zone_set_count > 7'd1;

  // structural sanity of the configuration
  wire logic params_ok =
      zone_set_count != 7'd0 &&
      zone_set_count <= `ZSS_MAX_SETS &&
      area_switch_input_count <= `ZSS_MAX_LINES &&
      !(zone_set_count == 7'd2 &&
        eff_lines < `ZSS_TWO_LINES) &&
      !(reduced_model && zone_set_count > `ZSS_REDUCED_MAX) &&
      !(multi && eff_lines == 4'd0);

  // pair check walks every (i,j) with i<j, one pair a cycle
  wire code_t pair_xor  = (cfg_codes[chk_i] ^ cfg_codes[chk_j]) & mask;
  wire logic  same_code = pair_xor == 8'h00;
  wire logic  speed_dif = cfg_speeds[chk_i] != cfg_speeds[chk_j];
  wire logic  pair_ok   = ones8(pair_xor) >= `ZSS_MIN_HAMMING ||
                          (encoder_enable && same_code &&
                           speed_dif);
  wire logic  last_j    = chk_j >= zone_set_count - 7'd1;
  wire logic  last_pair = !multi || (last_j &&
                          chk_i >= zone_set_count - 7'd2);
  wire logic  chk_fail  = !params_ok || chk_bad ||
                          (multi && !pair_ok);

  // lookup; a distinct code may share any speed range
  wire logic scan_hit = !multi ||
      (((cfg_codes[scan] & mask) == cur_code) &&
       (!encoder_enable ||
        cfg_speeds[scan] == speed_range));
  wire logic scan_end = scan >= zone_set_count - 7'd1;

  // a change in IDLE is the first transition of a switchover
  wire logic changed = multi && (cur_code != acc_code ||
      (encoder_enable && speed_range != acc_speed));
  wire logic [5:0] target = (delay_steps == 6'd0) ? 6'd1
                                                  : delay_steps;
  wire logic step_wrap = cyc_cnt == 22'(STEP_CYCLES - 1);
  wire logic expired   = step_cnt == target;

  always_comb
  begin
    next_state = state;
    case (state)
      S_CHECK:
        if (chk_fail)
          next_state = S_FAULT;
        else if (last_pair)
          next_state = S_LOOKUP;
      S_LOOKUP:
        if (scan_hit)
          next_state = S_IDLE;
        else if (scan_end)
          next_state = S_FAULT;
      S_IDLE:
        if (changed)
          next_state = S_SETTLE;
      S_SETTLE:
        if (expired)
          next_state = S_LOOKUP;
      S_FAULT:
        if (fault_clear)
          next_state = S_CHECK;
      default:
        next_state = S_FAULT;
    endcase
    if (cfg_wr && state != S_FAULT)
      next_state = S_CHECK;
  end

  // ------------------------------------------------------------
  // state and walkers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state   <= S_CHECK;
      chk_i   <= 7'd0;
      chk_j   <= 7'd1;
      chk_bad <= 1'b0;
      scan    <= 7'd0;
    end
    else
    begin
      state <= next_state;
      // a table write restarts the walk at the first pair
      if (state == S_CHECK && next_state == S_CHECK && !cfg_wr)
      begin
        chk_bad <= chk_fail;
        if (last_j)
        begin
          chk_i <= chk_i + 7'd1;
          chk_j <= chk_i + 7'd2;
        end
        else
          chk_j <= chk_j + 7'd1;
      end
      else
      begin
        chk_i   <= 7'd0;
        chk_j   <= 7'd1;
        chk_bad <= 1'b0;
      end
      if (state == S_LOOKUP && next_state == S_LOOKUP)
        scan <= scan + 7'd1;
      else
        scan <= 7'd0;
    end
  end

  // settling timer: no restart on later bounces
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cyc_cnt  <= 22'd0;
      step_cnt <= 6'd0;
    end
    else if (state == S_SETTLE && !expired)
    begin
      cyc_cnt <= step_wrap ? 22'd0 : cyc_cnt + 22'd1;
      if (step_wrap)
        step_cnt <= step_cnt + 6'd1;
    end
    else if (state != S_SETTLE)
    begin
      cyc_cnt  <= 22'd0;
      step_cnt <= 6'd0;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  wire logic accept = state == S_LOOKUP && scan_hit;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      active_set         <= 7'd0;
      active_valid       <= 1'b0;
      monitor_enable     <= 1'b0;
      config_valid       <= 1'b0;
      fault              <= 1'b0;
      safety_output_pair <= 2'b00;
      acc_code           <= 8'h00;
      acc_speed          <= 4'h0;
    end
    else
    begin
      if (accept)
      begin
        active_set <= multi ? scan : 7'd0;
        acc_code   <= cur_code;
        acc_speed  <= speed_range;
      end
      active_valid   <= next_state == S_IDLE || next_state == S_SETTLE;
      // old set stays selected, but nothing is judged until accepted
      monitor_enable <= next_state == S_IDLE;
      if (state == S_CHECK && next_state != S_CHECK)
        config_valid <= !chk_fail;
      else if (state == S_CHECK)
        config_valid <= 1'b0;
      fault <= next_state == S_FAULT;
      safety_output_pair <= (next_state == S_FAULT) ? 2'b00
                                                    : zone_clear;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_fault_outs_off: assert property (
    state == S_FAULT |-> safety_output_pair == 2'b00)
    else $error("outputs on during fault");
  a_settle_hold: assert property (
    state == S_SETTLE |=> $stable(active_set))
    else $error("set changed before delay expired");
  a_no_monitor: assert property (
    state == S_SETTLE |-> !monitor_enable)
    else $error("monitoring during changeover");
  a_settle_length: assert property (
    state == S_SETTLE && next_state == S_LOOKUP |->
      step_cnt == target && step_cnt != 6'd0)
    else $error("settle left at wrong step count");
  a_unresolved_fault: assert property (
    state == S_LOOKUP && !scan_hit && scan_end && !cfg_wr
      |=> fault ##0 state == S_FAULT)
    else $error("invalid code did not fault");

  a_single_set: assert property (
    active_valid |-> active_set < zone_set_count)
    else $error("active set out of range");
  a_change_intruded: assert property (
    state == S_IDLE && changed && !cfg_wr |=> state == S_SETTLE)
    else $error("change refused");
  a_bad_config: assert property (
    state == S_CHECK && chk_fail && !cfg_wr |=> fault)
    else $error("bad configuration not faulted");

endmodule // zone_set_selector

`default_nettype wire

// ### plc_model.sv
// Purpose: controller model driving the area switch lines
// Assumes: go is a one-cycle request sampled on ref_clk
// Notes:   bounces one line first, then settles on the target
`timescale 1ns/1ps
`default_nettype none
module plc_model
(
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic [7:0] target,
  output var  logic [7:0] area_sw_pin
);
  logic [7:0] diff;
  logic [1:0] cnt;
  assign diff = target ^ area_sw_pin;
  initial area_sw_pin = 8'h00;
  initial cnt = 2'h0;
  always @(posedge ref_clk)
  begin
    if (go)
    begin
      // lowest differing line moves early, a transient code
      area_sw_pin <= area_sw_pin ^ (diff & (~diff + 8'h01));
      cnt         <= 2'h3;
    end
    else if (cnt != 2'h0)
    begin
      cnt <= cnt - 2'h1;
      if (cnt == 2'h1)
        area_sw_pin <= target;
    end
  end
endmodule // plc_model
`default_nettype wire

// ### zone_set_selector_test.sv
// Purpose: self-checking bench for the zone set selector
// Assumes: settle step shortened to 20 cycles
// Notes:   four sets on three lines, codes two bits apart
`timescale 1ns/1ps
`default_nettype none
module zone_set_selector_test;
  import zone_set_selector_pkg::*;
  logic       ref_clk, reset_n, encoder_enable, cfg_wr, fault_clear, go;
  speed_t     speed_range, cfg_speed;
  set_idx_t   cfg_index, active_set;
  code_t      cfg_code, target, cur;
  logic [7:0] area_sw_pin;
  logic [1:0] zone_clear, safety_output_pair;
  logic       active_valid, monitor_enable, config_valid, fault;
  logic       reduced_model;
  set_idx_t   zone_set_count;
  logic [3:0] area_switch_input_count;
  logic [5:0] delay_steps;
  int         err_total, comparisons, n, i, k;
  localparam code_t CODES [4] = '{8'h00, 8'h03, 8'h05, 8'h06};

  zone_set_selector #(.STEP_CYCLES(20)) u_zone_set_selector (
    .ref_clk(ref_clk), .reset_n(reset_n), .area_sw_pin(area_sw_pin),
    .speed_range(speed_range), .encoder_enable(encoder_enable),
    .reduced_model(reduced_model), .zone_set_count(zone_set_count),
    .area_switch_input_count(area_switch_input_count),
    .delay_steps(delay_steps),
    .cfg_wr(cfg_wr), .cfg_index(cfg_index), .cfg_code(cfg_code),
    .cfg_speed(cfg_speed), .zone_clear(zone_clear),
    .fault_clear(fault_clear), .active_set(active_set),
    .active_valid(active_valid), .monitor_enable(monitor_enable),
    .config_valid(config_valid), .fault(fault),
    .safety_output_pair(safety_output_pair));
  plc_model u_plc_model (.ref_clk(ref_clk), .go(go), .target(target),
    .area_sw_pin(area_sw_pin));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic set_idx_t idx_of(input code_t c);
    idx_of = '0;
    for (int j = 0; j < 4; j++)
      if (CODES[j] == (c & 8'h07))
        idx_of = set_idx_t'(j);
  endfunction
  // zero steps counts as one step of 20 cycles
  function automatic int settle_len(input logic [5:0] s);
    settle_len = 20 * ((s == 6'h00) ? 1 : int'(s));
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    if (err_total == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task tick(input int c);
    repeat (c) @(negedge ref_clk);
  endtask
  task cfg(input set_idx_t x, input code_t c, input speed_t s);
    cfg_index = x;
    cfg_code = c;
    cfg_speed = s;
    cfg_wr = 1'b1;
    tick(1);
    cfg_wr = 1'b0;
    tick(1);
  endtask
  task clear_fault;
    fault_clear = 1'b1;
    tick(1);
    fault_clear = 1'b0;
    tick(1);
  endtask
  task wait_on;
    tick(3);
    for (n = 0; n < 400 && monitor_enable !== 1 && fault !== 1; n++)
      tick(1);
    if (n == 400)
    begin
      err_total++;
      report_and_stop;
    end
  endtask
  // old selection must hold and monitoring pause while settling
  task wait_change(input set_idx_t old);
    for (n = 1; n < 400; n++)
    begin
      tick(1);
      if (n == 10)
      begin
        chk(active_set, old);
        chk(monitor_enable, 0);
      end
      if (n > 10 && (monitor_enable === 1 || fault === 1))
        break;
    end
    if (n == 400)
    begin
      err_total++;
      report_and_stop;
    end
    chk(n >= settle_len(delay_steps) &&
        n <= settle_len(delay_steps) + 20, 1);
  endtask
  task move(input code_t c);
    target = c | code_t'(($urandom % 32) << 3);
    go = 1'b1;
    tick(1);
    go = 1'b0;
    wait_change(idx_of(cur));
    cur = c;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {reset_n, encoder_enable, cfg_wr, fault_clear, go} = 5'h00;
    {speed_range, cfg_speed, cfg_index, cfg_code} = '0;
    {target, cur, zone_clear} = '0;
    {reduced_model, zone_set_count, area_switch_input_count} =
      {1'b0, 7'h04, 4'h3};
    delay_steps = 6'h01;
    void'($urandom(5631));
    tick(5);
    reset_n = 1'b1;
    for (i = 0; i < 4; i++)
      cfg(set_idx_t'(i), CODES[i], 4'h0);
    clear_fault;
    wait_on;
    chk(config_valid, 1);
    chk(active_set, 0);
    chk(active_valid, 1);
    for (i = 0; i < 8; i++)
    begin
      zone_clear = (i == 0) ? 2'h0 : 2'($urandom);
      do k = $urandom % 4; while (CODES[k] == cur);
      move(CODES[k]);
      chk(active_set, k);
      chk(active_valid, 1);
      chk(safety_output_pair, zone_clear);
    end
    zone_clear = 2'h3;
    move(8'h01);
    chk(fault, 1);
    tick(5);
    chk(safety_output_pair, 0);
    target = 8'h03;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    tick(10);
    clear_fault;
    wait_on;
    chk(active_set, 1);
    cur = 8'h03;
    cfg(7'h01, 8'h01, 4'h0);
    wait_on;
    chk(config_valid, 0);
    chk(fault, 1);
    cfg(7'h01, 8'h03, 4'h0);
    clear_fault;
    wait_on;
    chk(config_valid, 1);
    // each of the four bad parameter sets below must end in the fault state
    for (i = 0; i < 4; i++)
    begin
      {reduced_model, zone_set_count, area_switch_input_count} =
        {1'b0, 7'h04, 4'h3};
      case (i)
        0: zone_set_count = 7'h47;
        1: area_switch_input_count = 4'h9;
        2: {zone_set_count, area_switch_input_count} = {7'h02, 4'h1};
        default: {reduced_model, zone_set_count} = {1'b1, 7'h07};
      endcase
      if (i == 0)
        cfg(7'h00, 8'h00, 4'h0);
      else
        clear_fault;
      wait_on;
      chk(fault, 1);
      chk(safety_output_pair, 0);
    end
    // reduced model forces three lines; the line count is only range-checked
    {reduced_model, zone_set_count, area_switch_input_count} =
      {1'b1, 7'h04, 4'h0};
    clear_fault;
    wait_on;
    chk(config_valid, 1);
    chk(active_set, 1);
    for (i = 0; i < 3; i++)
    begin
      delay_steps = 6'(i * 2);
      do k = 1 + $urandom % 3; while (CODES[k] == cur);
      move(CODES[k]);
      chk(active_set, k);
    end
    delay_steps = 6'h01;
    move(8'h00);
    encoder_enable = 1'b1;
    cfg(7'h03, 8'h00, 4'h1);
    wait_on;
    chk(active_set, 0);
    speed_range = 4'h1;
    wait_change(7'h00);
    chk(active_set, 3);
    report_and_stop;
  end
endmodule // zone_set_selector_test
`default_nettype wire
